// file: rtl/bgf_top.sv
`timescale 1ns/100ps
module bgf_top (
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic [bgf_pkg::PH_N-1:0] HIGH_CMD_IN_I,
   input wire logic [bgf_pkg::PH_N-1:0] LOW_CMD_IN_I,
   input wire logic COAST_ALL_N_I,
   input wire logic CLEAR_SLEEP_N_I,
   input wire logic STOP_ON_FAIL_EN_I,
   input wire logic [bgf_pkg::PH_N-1:0] LOW_SHORT_I,
   input wire logic VCC_UV_I,
   input wire logic VDD_UV_I,
   input wire logic TEMP_OVER_I,
   input wire logic TEMP_RECOVERED_I,
   input wire logic REG_READY_I,
   input wire logic FLAG_SECONDARY_I,
   output logic [bgf_pkg::PH_N-1:0] HIGH_GATE_OUT_O,
   output logic [bgf_pkg::PH_N-1:0] LOW_GATE_OUT_O,
   output logic [bgf_pkg::PH_N-1:0] LOW_GATE_OE_O,
   output logic FLAG_PRIMARY_O,
   output logic FLAG_PRIMARY_OE_O,
   output logic FLAG_SECONDARY_O,
   output logic FLAG_SECONDARY_OE_O,
   output logic REG_EN_O,
   output logic SLEEP_O
);
   import bgf_pkg::*;

   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   // Every pin in this group is sampled by two flip-flops before any
   // decision reads it, so a command edge reaches the gate outputs on
   // the third clock edge. The short, supply and temperature monitors
   // arrive already clean and skip this delay, which lets a short pull
   // its gate down one edge after it is seen.
   logic [PH_N-1:0] cmd_hi_s;
   logic [PH_N-1:0] cmd_lo_s;
   logic esf_s;
   logic coast_n_s;
   logic clr_n_s;
   logic sec_pin_s;

   // Commands settle inactive at reset, like a pulled-down pin.
   bgf_sync #(
      .W(2 * PH_N + 1),
      .RST_VAL(7'h00)
   ) u_sync_hi (
      .clk_i(REF_CLK_I),
      .nrst_i(NRST_I),
      .d_i({STOP_ON_FAIL_EN_I, LOW_CMD_IN_I, HIGH_CMD_IN_I}),
      .q_o({esf_s, cmd_lo_s, cmd_hi_s})
   );

   // Active-low levels settle released at reset.
   bgf_sync #(
      .W(3),
      .RST_VAL(3'h7)
   ) u_sync_lo (
      .clk_i(REF_CLK_I),
      .nrst_i(NRST_I),
      .d_i({FLAG_SECONDARY_I, CLEAR_SLEEP_N_I, COAST_ALL_N_I}),
      .q_o({sec_pin_s, clr_n_s, coast_n_s})
   );

   // ****************************************************************
   // Reset input low-time measurement.
   // ****************************************************************
   // The counter measures how long the clear input has been low. The
   // fault clear acts on every cycle past the pulse time, not once, so
   // a fault that returns while the pin is held low is cleared again.
   // The count stops at the shutdown figure and therefore never wraps
   // back into the pulse window during a long sleep request.
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] next_low_cnt;
   wire cnt_sat = (low_cnt == SHUTDOWN_CYC);
   wire fault_clr = ~clr_n_s & (low_cnt >= FAULT_CLEAR_CYC);
   wire shut_req = ~clr_n_s & cnt_sat;

   // Count while the input is low, saturate at the shutdown count.
   assign next_low_cnt = clr_n_s ? CNT_ZERO :
                         (cnt_sat ? low_cnt : low_cnt + CNT_ONE);

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         low_cnt <= CNT_ZERO;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end

   // ****************************************************************
   // Power sequencing.
   // ****************************************************************
   // A long clear request walks run, shutdown, sleep and wake in that
   // order. Shutdown keeps the low drivers sinking for the holdoff count
   // before they let go. Wake holds every gate off until the regulators
   // report ready, so the controller never meets a half-powered driver.
   // An illegal state code falls to sleep, the safest place to recover.
   bgf_state_t state;
   bgf_state_t next_state;
   logic [CNT_W-1:0] hold_cnt;
   logic [CNT_W-1:0] next_hold_cnt;
   wire hold_done = (hold_cnt == HOLDOFF_CYC - CNT_ONE);
   wire in_sleep = (state == ST_SLEEP);

   // Shutdown, sleep and wake sequence.
   always_comb begin
      next_state = state;
      next_hold_cnt = CNT_ZERO;
      case (state)
         ST_RUN: begin
            if (shut_req) begin
               next_state = ST_SHUT;
            end
         end
         ST_SHUT: begin
            next_hold_cnt = hold_cnt + CNT_ONE;
            if (hold_done) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (clr_n_s) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (REG_READY_I) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_SLEEP;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state <= ST_RUN;
         hold_cnt <= CNT_ZERO;
      end else begin
         state <= next_state;
         hold_cnt <= next_hold_cnt;
      end
   end

   // ****************************************************************
   // Fault capture.
   // ****************************************************************
   logic ot;
   logic [PH_N-1:0] short_flag;
   logic [FW_BITS-1:0] fw;
   logic read_done;
   logic next_ot;
   logic [PH_N-1:0] next_short_flag;
   logic [FW_BITS-1:0] next_fw;
   logic [FW_BITS-1:0] fw_set;
   wire any_uv = VCC_UV_I | VDD_UV_I;
   wire word_clr = fault_clr | read_done | in_sleep | VDD_UV_I;

   // Overtemperature holds until recovery below the hysteresis point.
   assign next_ot = TEMP_OVER_I
                    | (ot & ~TEMP_RECOVERED_I & ~in_sleep);

   // Latched short flags, each clear losing to a new short.
   assign next_short_flag = LOW_SHORT_I
      | (short_flag & ~({PH_N{word_clr}} | ~cmd_lo_s));

   // Word bits set from live conditions; power-on bit only at reset.
   always_comb begin
      fw_set = '0;
      fw_set[FW_POR] = 1'b0; // Set only by the reset value.
      fw_set[FW_PHASE_A_LOW_SHORT +: PH_N] = LOW_SHORT_I;
      fw_set[FW_SUPPLY_UV_SEEN] = VCC_UV_I;
   end
   assign next_fw = fw_set | (fw & ~{FW_BITS{word_clr}});

   // Coast is not an input to any of these latches.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ot <= 1'b0;
         short_flag <= '0;
         fw <= FW_RST;
      end else begin
         ot <= next_ot;
         short_flag <= next_short_flag;
         fw <= next_fw;
      end
   end

   // ****************************************************************
   // Flag levels.
   // ****************************************************************
   // Each flag is the OR of what every present fault asks of it. The
   // primary flag carries temperature and supplies, the secondary one
   // shorts and supplies, so an overtemperature alone keeps the word
   // closed. Coast appears nowhere here, which keeps the flags readable
   // while the bridge is parked.
   wire prim_fault = ot | any_uv;
   wire sec_fault = (|short_flag) | any_uv;

   // ****************************************************************
   // Serial fault word readout.
   // ****************************************************************
   // The controller clocks the word by pulling the secondary wire low.
   // The wire is seen through the synchroniser, so edges made by the
   // device itself also arrive here; they do no harm because a read can
   // only start while the secondary fault level is high. Losing that
   // level aborts a read part way and restarts the next one at bit 0.
   logic sec_q;
   logic rd_act;
   logic [2:0] rd_idx;
   logic next_rd_act;
   logic [2:0] next_rd_idx;
   wire sec_fall = sec_q & ~sec_pin_s;
   wire sec_rise = ~sec_q & sec_pin_s;
   wire rd_bit = fw[rd_idx];

   // The read completes when the last bit is released by a rise.
   assign read_done = sec_fault & rd_act & sec_rise
                      & (rd_idx == IDX_LAST);

   // Walk the word on falling edges of the secondary flag.
   always_comb begin
      next_rd_act = rd_act;
      next_rd_idx = rd_idx;
      if (!sec_fault) begin
         next_rd_act = 1'b0;
         next_rd_idx = IDX_FIRST;
      end else if (read_done) begin
         next_rd_act = 1'b0;
         next_rd_idx = IDX_FIRST;
      end else if (sec_fall && !rd_act) begin
         next_rd_act = 1'b1;
         next_rd_idx = IDX_FIRST;
      end else if (sec_fall && rd_idx != IDX_LAST) begin
         next_rd_idx = rd_idx + 3'h1;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sec_q <= 1'b1;
         rd_act <= 1'b0;
         rd_idx <= IDX_FIRST;
      end else begin
         sec_q <= sec_pin_s;
         rd_act <= next_rd_act;
         rd_idx <= next_rd_idx;
      end
   end

   // ****************************************************************
   // Phase gate logic.
   // ****************************************************************
   // One phase block per half-bridge applies lockout and short blocking.
   // The shared enable is computed once here so that every phase drops
   // in the same cycle when coast, sequencing or a supply fault acts.
   // A short blocks only its own low gate, leaving the other phases
   // free to keep braking or driving the motor.
   bgf_phase_if ph_if[PH_N] ();
   logic [PH_N-1:0] hi_next;
   logic [PH_N-1:0] lo_next;

   // Coast, sequencing, undervoltage and stop-on-fail all gate drive.
   wire gate_en = (state == ST_RUN) & coast_n_s & ~any_uv
                  & ~(ot & esf_s);

   genvar gi;
   generate
      for (gi = 0; gi < PH_N; gi++) begin : g_ph
         assign ph_if[gi].cmd_hi = cmd_hi_s[gi];
         assign ph_if[gi].cmd_lo = cmd_lo_s[gi];
         assign ph_if[gi].gate_en = gate_en;
         assign ph_if[gi].lo_short = LOW_SHORT_I[gi];
         assign hi_next[gi] = ph_if[gi].hi_gate;
         assign lo_next[gi] = ph_if[gi].lo_gate;
         bgf_phase u_phase (
            .clk_i(REF_CLK_I),
            .nrst_i(NRST_I),
            .ph(ph_if[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Output registers.
   // ****************************************************************
   // Every pin leaves through a flip-flop, so glitches on the decode
   // above never reach the bridge. The low driver enables and the
   // regulator follow the next state, which makes them switch in the
   // same edge as the state register rather than one cycle late and
   // keeps the holdoff exactly as long as the holdoff count.
   wire next_lo_oe = (next_state != ST_SLEEP);
   wire prim_level = rd_act ? rd_bit : prim_fault;

   // Open-drain flags pull low when the level is low.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         HIGH_GATE_OUT_O <= '0;
         LOW_GATE_OUT_O <= '0;
         LOW_GATE_OE_O <= '1;
         FLAG_PRIMARY_O <= 1'b0;
         FLAG_PRIMARY_OE_O <= 1'b1;
         FLAG_SECONDARY_O <= 1'b0;
         FLAG_SECONDARY_OE_O <= 1'b1;
         REG_EN_O <= 1'b1;
         SLEEP_O <= 1'b0;
      end else begin
         HIGH_GATE_OUT_O <= hi_next;
         LOW_GATE_OUT_O <= lo_next;
         LOW_GATE_OE_O <= {PH_N{next_lo_oe}};
         FLAG_PRIMARY_O <= prim_level;
         FLAG_PRIMARY_OE_O <= ~prim_level;
         FLAG_SECONDARY_O <= sec_fault;
         FLAG_SECONDARY_OE_O <= ~sec_fault;
         REG_EN_O <= (next_state != ST_SLEEP);
         SLEEP_O <= (next_state == ST_SLEEP);
      end
   end
endmodule : bgf_top

// file: rtl/bgf_pkg.sv
package bgf_pkg;
   // ****************************************************************
   // Geometry.
   // ****************************************************************
   localparam int PH_N = 3;
   localparam int CNT_W = 9;
   localparam int FW_BITS = 5;

   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int SHUTDOWN_HOLD_TIME_NS = 10000;
   localparam int LOW_DRIVE_HOLDOFF_TIME_NS = 2000;
   localparam int FAULT_CLEAR_PULSE_TIME_NS = 1000;
   // Least times, rounded up to whole cycles.
   localparam logic [CNT_W-1:0] SHUTDOWN_CYC = CNT_W'(
      (SHUTDOWN_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLDOFF_CYC = CNT_W'(
      (LOW_DRIVE_HOLDOFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FAULT_CLEAR_CYC = CNT_W'(
      (FAULT_CLEAR_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

   // ****************************************************************
   // Fault word layout, bit 0 is shifted out first.
   // ****************************************************************
   localparam int FW_POR = 0;
   localparam int FW_PHASE_A_LOW_SHORT = 1;
   localparam int FW_SUPPLY_UV_SEEN = 4;
   localparam logic [FW_BITS-1:0] FW_RST = 5'h01;
   localparam logic [2:0] IDX_FIRST = 3'h0;
   localparam logic [2:0] IDX_LAST = 3'h4;

   // ****************************************************************
   // Power sequencing states.
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_SHUT = 2'h1,
      ST_SLEEP = 2'h3,
      ST_WAKE = 2'h2
   } bgf_state_t;
endpackage : bgf_pkg

// file: rtl/bgf_phase_if.sv
`timescale 1ns/100ps
// Signals between the controller and one half-bridge phase.
interface bgf_phase_if;
   logic cmd_hi;
   logic cmd_lo;
   logic gate_en;
   logic lo_short;
   logic hi_gate;
   logic lo_gate;
   modport phase (
      input cmd_hi,
      input cmd_lo,
      input gate_en,
      input lo_short,
      output hi_gate,
      output lo_gate
   );
   modport ctrl (
      output cmd_hi,
      output cmd_lo,
      output gate_en,
      output lo_short,
      input hi_gate,
      input lo_gate
   );
endinterface : bgf_phase_if

// file: rtl/bgf_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a group of level inputs.
module bgf_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : bgf_sync

// file: rtl/bgf_phase.sv
`timescale 1ns/100ps
// Gate decision for one phase: lockout and low-side short blocking.
module bgf_phase (
   input wire logic clk_i,
   input wire logic nrst_i,
   bgf_phase_if.phase ph
);
   logic lo_block;
   logic next_lo_block;
   wire both_cmd = ph.cmd_hi & ph.cmd_lo;

   // A short holds the low switch off until its command drops.
   assign next_lo_block = ph.lo_short | (lo_block & ph.cmd_lo);

   // Each command steers only its own gate; both at once gives none.
   assign ph.hi_gate = ph.gate_en & ph.cmd_hi & ~both_cmd;
   assign ph.lo_gate = ph.gate_en & ph.cmd_lo & ~both_cmd
                       & ~lo_block & ~ph.lo_short;

   // Short blocking latch.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lo_block <= 1'b0;
      end else begin
         lo_block <= next_lo_block;
      end
   end
endmodule : bgf_phase

// file: verif/bgf_props.sv
`timescale 1ns/100ps
// Watches the gate and flag outputs of the bridge control block.
module bgf_props
   import bgf_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic [bgf_pkg::PH_N-1:0] HIGH_CMD_IN_I,
   input wire logic [bgf_pkg::PH_N-1:0] LOW_CMD_IN_I,
   input wire logic COAST_ALL_N_I,
   input wire logic STOP_ON_FAIL_EN_I,
   input wire logic [bgf_pkg::PH_N-1:0] LOW_SHORT_I,
   input wire logic TEMP_OVER_I,
   input wire logic REG_READY_I,
   input wire logic [bgf_pkg::PH_N-1:0] HIGH_GATE_OUT_O,
   input wire logic [bgf_pkg::PH_N-1:0] LOW_GATE_OUT_O,
   input wire logic [bgf_pkg::PH_N-1:0] LOW_GATE_OE_O,
   input wire logic FLAG_SECONDARY_OE_O,
   input wire logic REG_EN_O,
   input wire logic SLEEP_O
);
   logic [5:0] hold_cnt;
   default clocking @(posedge REF_CLK_I);
   endclocking
   default disable iff (!NRST_I);
   // Counts cycles of low-side drivers actively holding all low gates off.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         hold_cnt <= 6'h00;
      end else if (LOW_GATE_OE_O == 3'h7 && LOW_GATE_OUT_O == 3'h0) begin
         hold_cnt <= (hold_cnt == 6'h3f) ? hold_cnt : hold_cnt + 6'h01;
      end else begin
         hold_cnt <= 6'h00;
      end
   end
   gate_lockout_a: assert property (
      (HIGH_GATE_OUT_O & LOW_GATE_OUT_O) == 3'h0)
      else $error("high and low gate of one phase both on");
   high_cause_a: assert property (
      (HIGH_GATE_OUT_O & ~$past(HIGH_CMD_IN_I, 3)) == 3'h0)
      else $error("high gate on without its command");
   low_cause_a: assert property (
      (LOW_GATE_OUT_O & ~$past(LOW_CMD_IN_I, 3)) == 3'h0)
      else $error("low gate on without its command");
   coast_gates_a: assert property (
      (!COAST_ALL_N_I)[*4] |-> (HIGH_GATE_OUT_O | LOW_GATE_OUT_O) == 3'h0)
      else $error("gate on while coasting");
   over_temp_stop_a: assert property (
      (TEMP_OVER_I && STOP_ON_FAIL_EN_I)[*4] |=>
      (HIGH_GATE_OUT_O | LOW_GATE_OUT_O) == 3'h0)
      else $error("gate on after overtemperature with stop enabled");
   sleep_holdoff_a: assert property (
      $rose(SLEEP_O) |-> {3'h0, hold_cnt} >= HOLDOFF_CYC - CNT_ONE)
      else $error("low drivers released before the holdoff ran out");
   sleep_off_a: assert property (
      SLEEP_O |-> LOW_GATE_OE_O == 3'h0 && !REG_EN_O)
      else $error("drivers or regulator active in sleep");
   wake_off_a: assert property (
      $fell(SLEEP_O) ##0 (!REG_READY_I)[*3] |=>
      (HIGH_GATE_OUT_O | LOW_GATE_OUT_O) == 3'h0)
      else $error("gate on before regulators ready");
   short_flag_a: assert property (
      LOW_SHORT_I != 3'h0 |-> ##[1:2] !FLAG_SECONDARY_OE_O)
      else $error("secondary flag not raised by low-side short");
endmodule : bgf_props
bind bgf_top bgf_props u_bgf_props (.*);

// file: verif/bgf_ctrl_model.sv
`timescale 1ns/100ps
// Motor controller side of the two open-drain fault flag wires.
module bgf_ctrl_model (
   input wire logic clk_i,
   input wire logic prim_oe_i,
   input wire logic sec_oe_i,
   output logic prim_lvl_o,
   output logic sec_lvl_o
);
   logic sec_pull = 1'b0;
   // Both wires have pull-ups, so either party pulling low wins.
   assign prim_lvl_o = !prim_oe_i;
   assign sec_lvl_o = !(sec_oe_i || sec_pull);
   // Clocks the fault word out, sampling each bit while the flag is low.
   task automatic read_word(output logic [4:0] w);
      w = 5'h00;
      if (sec_lvl_o) begin
         for (int i = 0; i < 5; i++) begin
            @(negedge clk_i);
            sec_pull = 1'b1;
            repeat (6) @(negedge clk_i);
            w[i] = prim_lvl_o;
            sec_pull = 1'b0;
            repeat (6) @(negedge clk_i);
         end
      end
   endtask : read_word
endmodule : bgf_ctrl_model

// file: verif/bgf_top_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
// Drives the bridge control block as its motor controller would.
module bgf_top_test;
   import bgf_pkg::*;
   int failures = 0;
   int checks_done = 0;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] hi = 3'h0;
   logic [2:0] lo = 3'h0;
   logic coast_n = 1'b1;
   logic clear_sleep_n = 1'b1;
   logic stop_en = 1'b0;
   logic [2:0] short_in = 3'h0;
   logic vcc_uv = 1'b0;
   logic vdd_uv = 1'b0;
   logic t_over = 1'b0;
   logic t_rec = 1'b0;
   logic ready = 1'b1;
   logic [2:0] hg;
   logic [2:0] lg;
   logic [2:0] loe;
   logic p_oe, s_oe, p_lvl, s_lvl, reg_en, sleep;
   logic p_o, s_o;
   logic [4:0] word;
   // Free-running reference clock.
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   bgf_top u_bgf_top (
      .REF_CLK_I(clk),
      .NRST_I(nrst),
      .HIGH_CMD_IN_I(hi),
      .LOW_CMD_IN_I(lo),
      .COAST_ALL_N_I(coast_n),
      .CLEAR_SLEEP_N_I(clear_sleep_n),
      .STOP_ON_FAIL_EN_I(stop_en),
      .LOW_SHORT_I(short_in),
      .VCC_UV_I(vcc_uv),
      .VDD_UV_I(vdd_uv),
      .TEMP_OVER_I(t_over),
      .TEMP_RECOVERED_I(t_rec),
      .REG_READY_I(ready),
      .FLAG_SECONDARY_I(s_lvl),
      .HIGH_GATE_OUT_O(hg),
      .LOW_GATE_OUT_O(lg),
      .LOW_GATE_OE_O(loe),
      .FLAG_PRIMARY_O(p_o),
      .FLAG_PRIMARY_OE_O(p_oe),
      .FLAG_SECONDARY_O(s_o),
      .FLAG_SECONDARY_OE_O(s_oe),
      .REG_EN_O(reg_en),
      .SLEEP_O(sleep)
   );
   bgf_ctrl_model u_bgf_ctrl_model (
      .clk_i(clk),
      .prim_oe_i(p_oe),
      .sec_oe_i(s_oe),
      .prim_lvl_o(p_lvl),
      .sec_lvl_o(s_lvl)
   );
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic gates(input logic [2:0] eh, input logic [2:0] el);
      step(4);
      `CHK("high gates", eh, hg)
      `CHK("low gates", el, lg)
   endtask : gates
   task automatic flags(input logic ep, input logic es);
      step(3);
      `CHK("primary flag", ep, p_lvl)
      `CHK("secondary flag", es, s_lvl)
      `CHK("primary level", ep, p_o)
      `CHK("secondary level", es, s_o)
   endtask : flags
   task automatic pulse_short(input logic [2:0] s);
      short_in = s;
      step(1);
      short_in = 3'h0;
   endtask : pulse_short
   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   // Main sequence: commands, shorts, supplies, temperature, reset.
   initial begin
      step(6);
      nrst = 1'b1;
      step(2);
      hi = 3'h5;
      lo = 3'h2;
      gates(3'h5, 3'h2);
      hi = 3'h2;
      lo = 3'h5;
      gates(3'h2, 3'h5);
      hi = 3'h7;
      lo = 3'h7;
      gates(3'h0, 3'h0);
      hi = 3'h0;
      gates(3'h0, 3'h7);
      $display("test commands done");
      pulse_short(3'h1);
      gates(3'h0, 3'h6);
      flags(1'b0, 1'b1);
      coast_n = 1'b0;
      gates(3'h0, 3'h0);
      flags(1'b0, 1'b1);
      coast_n = 1'b1;
      u_bgf_ctrl_model.read_word(word);
      `CHK("fault word", 5'h03, word)
      flags(1'b0, 1'b0);
      $display("test short done");
      pulse_short(3'h2);
      vcc_uv = 1'b1;
      flags(1'b1, 1'b1);
      gates(3'h0, 3'h0);
      vcc_uv = 1'b0;
      flags(1'b0, 1'b1);
      u_bgf_ctrl_model.read_word(word);
      `CHK("fault word", 5'h14, word)
      flags(1'b0, 1'b0);
      $display("test undervoltage done");
      lo = 3'h0;
      step(4);
      lo = 3'h7;
      t_over = 1'b1;
      step(1);
      t_over = 1'b0;
      flags(1'b1, 1'b0);
      gates(3'h0, 3'h7);
      lo = 3'h0;
      t_rec = 1'b1;
      step(1);
      t_rec = 1'b0;
      flags(1'b0, 1'b0);
      lo = 3'h7;
      stop_en = 1'b1;
      t_over = 1'b1;
      gates(3'h0, 3'h0);
      t_over = 1'b0;
      flags(1'b1, 1'b0);
      t_rec = 1'b1;
      step(1);
      t_rec = 1'b0;
      gates(3'h0, 3'h7);
      $display("test temperature done");
      pulse_short(3'h4);
      flags(1'b0, 1'b1);
      clear_sleep_n = 1'b0;
      step(30);
      clear_sleep_n = 1'b1;
      flags(1'b0, 1'b0);
      `CHK("sleep", 1'b0, sleep)
      vcc_uv = 1'b1;
      flags(1'b1, 1'b1);
      u_bgf_ctrl_model.read_word(word);
      `CHK("fault word", 5'h10, word)
      vcc_uv = 1'b0;
      pulse_short(3'h1);
      vdd_uv = 1'b1;
      flags(1'b1, 1'b1);
      vdd_uv = 1'b0;
      flags(1'b0, 1'b0);
      $display("test pulse done");
      clear_sleep_n = 1'b0;
      step(270);
      `CHK("low drive enables", 3'h7, loe)
      `CHK("low gates", 3'h0, lg)
      step(50);
      `CHK("sleep", 1'b1, sleep)
      `CHK("low drive enables", 3'h0, loe)
      `CHK("regulator", 1'b0, reg_en)
      lo = 3'h0;
      step(4);
      lo = 3'h7;
      ready = 1'b0;
      clear_sleep_n = 1'b1;
      step(10);
      `CHK("sleep", 1'b0, sleep)
      `CHK("low gates", 3'h0, lg)
      ready = 1'b1;
      gates(3'h0, 3'h7);
      lo = 3'h0;
      hi = 3'h7;
      gates(3'h7, 3'h0);
      $display("test sleep done");
      final_report();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      step(3000);
      failures++;
      final_report();
   end
endmodule : bgf_top_test
